// ===== hw/plut_map.vh
// constants for the piecewise lookup table block
// assumes a 40 MHz core clock and word-aligned AHB-Lite register access
// Notes on behaviour
// - at most ten segments, points 0..10
// - data mode: selected input is x
// - time mode: x is milliseconds, input enables
// - time mode repeat restarts after last point
// - segment type: 0 ignore, 1 ramp, 2 step
// - ramp interpolates linearly between bounding points
// - step segment outputs the ending point's y
// - point zero is always a step
// - ignore drops that point and all above
// - x values kept non-decreasing by index
// - output range is min and max y
// - ignored points excluded from min and max
`ifndef PLUT_MAP_VH
`define PLUT_MAP_VH

`define PLUT_NPTS 4'hB
`define PLUT_LAST_PT 10
`define PLUT_XW 16
`define PLUT_YW 16

`define PLUT_CLK_HZ 40000000
`define PLUT_HZ_PER_KHZ 1000
`define PLUT_TICK_MS 1
`define PLUT_CYC_PER_MS (`PLUT_CLK_HZ / `PLUT_HZ_PER_KHZ * `PLUT_TICK_MS)

`define PLUT_SEG_IGNORE 2'h0
`define PLUT_SEG_LINEAR 2'h1
`define PLUT_SEG_STEP 2'h2

`define PLUT_AXIS_DATA 1'b0
`define PLUT_AXIS_TIME 1'b1

`define PLUT_OFF_CTRL 8'h00
`define PLUT_OFF_OUT 8'h04
`define PLUT_OFF_MIN 8'h08
`define PLUT_OFF_MAX 8'h0C
`define PLUT_OFF_TIME 8'h10
`define PLUT_REGION_CTL 2'h0
`define PLUT_REGION_X 2'h1
`define PLUT_REGION_Y 2'h2
`define PLUT_REGION_SEG 2'h3

`define PLUT_CTRL_AXIS 0
`define PLUT_CTRL_RPT 1
`define PLUT_CTRL_SEL_LO 4
`define PLUT_CTRL_SEL_HI 7

`define PLUT_RST_CTRL 8'h00
`define PLUT_RST_X 16'h0000
`define PLUT_RST_Y 16'h0000
`define PLUT_RST_SEG `PLUT_SEG_IGNORE

`endif

// ===== hw/plut_div.v
// unsigned restoring divider, one quotient bit per enabled clock
// assumes den is non-zero and num/den stay stable only at start
`timescale 1ns/1ps
`default_nettype none

module plut_div #(
	parameter NW = 32,
	parameter DW = 16
) (
	input wire core_clk,
	input wire rst,
	input wire ce,
	input wire start,
	input wire [NW-1:0] num,
	input wire [DW-1:0] den,
	output reg done,
	output reg [NW-1:0] quo
);

localparam CW = $clog2(NW + 1);

reg [NW-1:0] q_reg;
reg [DW:0] r_reg;
reg [DW-1:0] d_reg;
reg [CW-1:0] cnt_reg;
reg busy_reg;
wire [DW:0] trial;
wire fits;

assign trial = {r_reg[DW-1:0], q_reg[NW-1]};
assign fits = trial >= {1'b0, d_reg};

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		q_reg <= {NW{1'b0}};
		r_reg <= {(DW+1){1'b0}};
		d_reg <= {DW{1'b0}};
		cnt_reg <= {CW{1'b0}};
		busy_reg <= 1'b0;
		done <= 1'b0;
		quo <= {NW{1'b0}};
	end else if (ce) begin
		done <= 1'b0;
		if (start && !busy_reg) begin
			q_reg <= num;
			r_reg <= {(DW+1){1'b0}};
			d_reg <= den;
			cnt_reg <= NW[CW-1:0];
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			r_reg <= fits ? trial - {1'b0, d_reg} : trial;
			q_reg <= {q_reg[NW-2:0], fits};
			cnt_reg <= cnt_reg - 1'b1;
			if (cnt_reg == 1) begin
				busy_reg <= 1'b0;
				done <= 1'b1;
				quo <= {q_reg[NW-2:0], fits};
			end
		end
	end
end

endmodule
`default_nettype wire

// ===== hw/plut_core.v
// piecewise lookup table with AHB-Lite setup registers
// assumes in_data comes from logic on core_clk; the bus is the only master
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "plut_map.vh"

module plut_core #(
	parameter NUM_IN = 4,
	parameter CYC_PER_MS = `PLUT_CYC_PER_MS
) (
	input wire core_clk,
	input wire rst,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire [NUM_IN*16-1:0] in_data,
	output reg [15:0] out_value,
	output reg [15:0] out_min,
	output reg [15:0] out_max,
	output reg out_valid
);

localparam S_FIND = 3'b001;
localparam S_DIV = 3'b010;
localparam S_DONE = 3'b100;
integer i;

////////////////////////////////////////////////////////////////////////
// setup storage
reg [15:0] x_reg [0:`PLUT_LAST_PT];
reg [15:0] y_reg [0:`PLUT_LAST_PT];
reg [1:0] seg_reg [0:`PLUT_LAST_PT];
reg axis_reg;
reg rpt_reg;
reg [3:0] sel_reg;
reg [15:0] time_reg;
reg [15:0] presc_reg;
reg en_q_reg;
reg [2:0] state_reg;

////////////////////////////////////////////////////////////////////////
// AHB-Lite slave: zero wait, reads answered from a flop in the data phase
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
wire take;
wire [1:0] a_region;
wire [3:0] a_idx;
wire [1:0] w_region;
wire [3:0] w_idx;
wire w_idx_ok;
// ce low stalls the bus so nothing is taken while state is frozen
assign hreadyout = ce;
assign hresp = 1'b0;
assign take = hsel && htrans[1] && hready && ce;
assign a_region = haddr[7:6];
assign a_idx = haddr[5:2];
assign w_region = wr_addr_reg[7:6];
assign w_idx = wr_addr_reg[5:2];
assign w_idx_ok = w_idx <= `PLUT_LAST_PT;

////////////////////////////////////////////////////////////////////////
// active points and output range
reg [3:0] n_act;
reg cut_found;
reg signed [15:0] ymin;
reg signed [15:0] ymax;
wire [15:0] last_x;
always @* begin
	n_act = `PLUT_NPTS;
	cut_found = 1'b0;
	for (i = 1; i <= `PLUT_LAST_PT; i = i + 1) begin
		if (!cut_found && seg_reg[i] == `PLUT_SEG_IGNORE) begin
			n_act = i[3:0];
			cut_found = 1'b1;
		end
	end
	ymin = y_reg[0];
	ymax = y_reg[0];
	for (i = 1; i <= `PLUT_LAST_PT; i = i + 1) begin
		if (i < n_act) begin
			if ($signed(y_reg[i]) < ymin)
				ymin = y_reg[i];
			if ($signed(y_reg[i]) > ymax)
				ymax = y_reg[i];
		end
	end
end
assign last_x = x_reg[n_act - 4'h1];

////////////////////////////////////////////////////////////////////////
// x write clamp keeps the axis non-decreasing
reg [15:0] w_lo;
reg [15:0] w_hi;
reg [15:0] w_x;
always @* begin
	w_lo = 16'h0000;
	w_hi = 16'hFFFF;
	if (w_idx != 4'h0 && w_idx_ok)
		w_lo = x_reg[w_idx - 4'h1];
	if (w_idx < `PLUT_LAST_PT)
		w_hi = x_reg[w_idx + 4'h1];
	// raising x is done top-down by software, else the clamp bites
	w_x = hwdata[15:0];
	if (w_x < w_lo)
		w_x = w_lo;
	if (w_x > w_hi)
		w_x = w_hi;
end

////////////////////////////////////////////////////////////////////////
// input selection and axis source
reg [15:0] sel_val;
wire en_now;
wire en_rise;
wire tick;
wire [15:0] xin;
always @* begin
	sel_val = in_data[15:0];
	for (i = 0; i < NUM_IN; i = i + 1) begin
		if (sel_reg == i[3:0])
			sel_val = in_data[i*16 +: 16];
	end
end
assign en_now = sel_val != 16'h0000;
assign en_rise = en_now && !en_q_reg;
assign tick = presc_reg == CYC_PER_MS[15:0] - 16'h0001;
assign xin = (axis_reg == `PLUT_AXIS_TIME) ? time_reg : sel_val;

////////////////////////////////////////////////////////////////////////
// segment search
reg [3:0] k;
reg hit;
reg at_start;
reg [15:0] dx;
reg [15:0] dxx;
reg signed [16:0] dy;
reg [16:0] dy_mag;
reg [15:0] direct_y;
reg need_div;
always @* begin
	k = 4'h0;
	hit = 1'b0;
	at_start = xin <= x_reg[0] || n_act == 4'h1;
	for (i = 1; i <= `PLUT_LAST_PT; i = i + 1) begin
		if (!hit && i < n_act && xin <= x_reg[i]) begin
			k = i[3:0];
			hit = 1'b1;
		end
	end
	dx = 16'h0000;
	dxx = 16'h0000;
	dy = 17'h0;
	if (hit) begin
		dx = x_reg[k] - x_reg[k - 4'h1];
		dxx = xin - x_reg[k - 4'h1];
		dy = {y_reg[k][15], y_reg[k]} - {y_reg[k-4'h1][15], y_reg[k-4'h1]};
	end
	dy_mag = dy[16] ? 17'h0 - dy : dy;
	need_div = 1'b0;
	if (at_start)
		direct_y = y_reg[0];
	else if (!hit)
		direct_y = y_reg[n_act - 4'h1];
	else if (seg_reg[k] == `PLUT_SEG_STEP)
		direct_y = y_reg[k];
	else begin
		// a zero-width ramp has nothing to divide, so it reports y[k]
		direct_y = y_reg[k];
		need_div = dx != 16'h0000;
	end
end

////////////////////////////////////////////////////////////////////////
// interpolation divide
reg [15:0] base_reg;
reg neg_reg;
wire div_done;
wire [31:0] quo;
wire [31:0] prod;
wire [16:0] q_s;
wire [16:0] ramp_y;
assign prod = dy_mag[15:0] * dxx;
assign q_s = neg_reg ? 17'h0 - quo[16:0] : quo[16:0];
assign ramp_y = {base_reg[15], base_reg} + q_s;
plut_div #(.NW(32), .DW(16)) u_div (
	.core_clk(core_clk),
	.rst(rst),
	.ce(ce),
	.start(state_reg == S_FIND && need_div),
	.num(prod),
	.den(dx),
	.done(div_done),
	.quo(quo)
);

////////////////////////////////////////////////////////////////////////
// sequential logic
always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		for (i = 0; i <= `PLUT_LAST_PT; i = i + 1) begin
			x_reg[i] <= `PLUT_RST_X;
			y_reg[i] <= `PLUT_RST_Y;
			seg_reg[i] <= `PLUT_RST_SEG;
		end
		seg_reg[0] <= `PLUT_SEG_STEP;
		axis_reg <= `PLUT_AXIS_DATA;
		rpt_reg <= 1'b0;
		sel_reg <= 4'h0;
		wr_pend_reg <= 1'b0;
		wr_addr_reg <= 8'h00;
		hrdata <= 32'h00000000;
	end else if (ce) begin
		seg_reg[0] <= `PLUT_SEG_STEP;
		wr_pend_reg <= take && hwrite;
		if (take)
			wr_addr_reg <= haddr[7:0];
		if (wr_pend_reg) begin
			if (wr_addr_reg == `PLUT_OFF_CTRL) begin
				axis_reg <= hwdata[`PLUT_CTRL_AXIS];
				rpt_reg <= hwdata[`PLUT_CTRL_RPT];
				sel_reg <= hwdata[`PLUT_CTRL_SEL_HI:`PLUT_CTRL_SEL_LO];
			end
			if (w_region == `PLUT_REGION_X && w_idx_ok)
				x_reg[w_idx] <= w_x;
			if (w_region == `PLUT_REGION_Y && w_idx_ok)
				y_reg[w_idx] <= hwdata[15:0];
			if (w_region == `PLUT_REGION_SEG && w_idx_ok && w_idx != 4'h0)
				seg_reg[w_idx] <= hwdata[1:0];
		end
		if (take && !hwrite) begin
			hrdata <= 32'h00000000;
			case (a_region)
			`PLUT_REGION_CTL: begin
				if (haddr[7:0] == `PLUT_OFF_CTRL)
					hrdata <= {24'h000000, sel_reg, 2'h0, rpt_reg, axis_reg};
				if (haddr[7:0] == `PLUT_OFF_OUT)
					hrdata <= {{16{out_value[15]}}, out_value};
				if (haddr[7:0] == `PLUT_OFF_MIN)
					hrdata <= {{16{out_min[15]}}, out_min};
				if (haddr[7:0] == `PLUT_OFF_MAX)
					hrdata <= {{16{out_max[15]}}, out_max};
				if (haddr[7:0] == `PLUT_OFF_TIME)
					hrdata <= {16'h0000, time_reg};
			end
			`PLUT_REGION_X: begin
				if (a_idx <= `PLUT_LAST_PT)
					hrdata <= {16'h0000, x_reg[a_idx]};
			end
			`PLUT_REGION_Y: begin
				if (a_idx <= `PLUT_LAST_PT)
					hrdata <= {{16{y_reg[a_idx][15]}}, y_reg[a_idx]};
			end
			default: begin
				if (a_idx <= `PLUT_LAST_PT)
					hrdata <= {30'h0, seg_reg[a_idx]};
			end
			endcase
		end
	end
end

// elapsed-time axis; in data mode it parks at zero
always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		time_reg <= 16'h0000;
		presc_reg <= 16'h0000;
		en_q_reg <= 1'b0;
	end else if (ce) begin
		en_q_reg <= en_now;
		if (axis_reg != `PLUT_AXIS_TIME || en_rise) begin
			time_reg <= 16'h0000;
			presc_reg <= 16'h0000;
		end else if (en_now) begin
			presc_reg <= tick ? 16'h0000 : presc_reg + 16'h0001;
			if (tick) begin
				if (time_reg < last_x)
					time_reg <= time_reg + 16'h0001;
				else if (rpt_reg)
					time_reg <= 16'h0000;
			end
		end
	end
end

// evaluation loop: one result per pass, ramps wait for the divider
always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		state_reg <= S_FIND;
		base_reg <= 16'h0000;
		neg_reg <= 1'b0;
		out_value <= 16'h0000;
		out_min <= 16'h0000;
		out_max <= 16'h0000;
		out_valid <= 1'b0;
	end else if (ce) begin
		out_valid <= 1'b0;
		out_min <= ymin;
		out_max <= ymax;
		case (state_reg)
		S_FIND: begin
			if (need_div) begin
				base_reg <= y_reg[k - 4'h1];
				neg_reg <= dy[16];
				state_reg <= S_DIV;
			end else begin
				out_value <= direct_y;
				out_valid <= 1'b1;
				state_reg <= S_DONE;
			end
		end
		S_DIV: begin
			if (div_done) begin
				out_value <= ramp_y[15:0];
				out_valid <= 1'b1;
				state_reg <= S_DONE;
			end
		end
		// S_DONE and any stray code go back to the search
		default: begin
			state_reg <= S_FIND;
		end
		endcase
	end
end

endmodule
`default_nettype wire

// ===== verification/plut_props.sv
// port checker for the lookup table block
// bound into every plut_core; sees only its ports
`timescale 1ns/1ps
`default_nettype none

module plut_props (
	input wire core_clk,
	input wire rst,
	input wire ce,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire [15:0] out_value,
	input wire [15:0] out_min,
	input wire [15:0] out_max,
	input wire out_valid
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);

////////////////////////////////////////
wire take = hsel && htrans[1] && hready && ce;
wire rd_take = take && !hwrite;
logic [5:0] gap_reg;
// ramps take about 35 cycles, so 48 leaves margin
always @(posedge core_clk or posedge rst) begin
	if (rst)
		gap_reg <= 6'h00;
	else if (out_valid)
		gap_reg <= 6'h00;
	else if (ce)
		gap_reg <= gap_reg + 6'h01;
end

property p_okay; hresp == 1'b0; endproperty
property p_ready; hreadyout == ce; endproperty
property p_range; $signed(out_min) <= $signed(out_max); endproperty
property p_hold; !out_valid |-> $stable(out_value); endproperty
property p_pulse; out_valid && ce |=> !out_valid; endproperty
property p_freeze;
	!ce |=> $stable(out_value) && $stable(out_min) && $stable(out_max);
endproperty
property p_rdata; !$stable(hrdata) |-> $past(rd_take); endproperty
property p_live; gap_reg < 6'h30; endproperty

a_okay: assert property (p_okay) else $error("hresp not okay");
a_ready: assert property (p_ready) else $error("hreadyout not ce");
a_range: assert property (p_range) else $error("min above max");
a_hold: assert property (p_hold) else $error("output moved silently");
a_pulse: assert property (p_pulse) else $error("valid longer than one");
a_freeze: assert property (p_freeze) else $error("moved while frozen");
a_rdata: assert property (p_rdata) else $error("hrdata moved unasked");
a_live: assert property (p_live) else $error("no output update");

c_valid: cover property (out_valid);
c_read: cover property (rd_take);
c_write: cover property (take && hwrite);
endmodule

bind plut_core plut_props props_u (.core_clk(core_clk), .rst(rst),
	.ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .out_value(out_value), .out_min(out_min),
	.out_max(out_max), .out_valid(out_valid));
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for plut_core over AHB-Lite
// one slave, so hready is fed back from hreadyout
`timescale 1ns/1ps
`default_nettype none

module testbench;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic ce = 1'b1;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [31:0] hwdata = 32'h0;
logic [63:0] in_data = 64'h0;
wire hreadyout, hresp, out_valid;
wire [31:0] hrdata;
wire [15:0] out_value, out_min, out_max;
int num_errors = 0;
int samples_checked = 0;
logic [31:0] rd, t;
logic [15:0] xs [6] = '{16'h0000, 16'h0032, 16'h0063, 16'h0064,
	16'h0096, 16'h01F4};
logic [15:0] ys [6] = '{16'h0014, 16'hFFF1, 16'hFFCF, 16'hFFCE,
	16'h012C, 16'h012C};
int i;

always #12.5 core_clk = ~core_clk;

plut_core #(.NUM_IN(4), .CYC_PER_MS(4)) dut_u (.core_clk(core_clk),
	.rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.in_data(in_data), .out_value(out_value), .out_min(out_min),
	.out_max(out_max), .out_valid(out_valid));

////////////////////////////////////////
task check(input logic [31:0] seen, input logic [31:0] exp);
	samples_checked++;
	if (seen !== exp) begin
		num_errors++;
		$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
	end
endtask

task give_verdict;
	$display("errors %0d checks %0d", num_errors, samples_checked);
	if (num_errors == 0 && samples_checked > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask

task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	hsel <= 1'b1;
	haddr <= {24'h000000, a};
	hwrite <= w;
	htrans <= 2'h2;
	@(posedge core_clk);
	while (hreadyout !== 1'b1) @(posedge core_clk);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	@(posedge core_clk);
	while (hreadyout !== 1'b1) @(posedge core_clk);
	rd = hrdata;
endtask

task rchk(input logic [7:0] a, input logic [31:0] e);
	bus(1'b0, a, 32'h0);
	check(rd, e);
endtask

// three pulses so the last one comes from a fresh sample
task ochk(input logic [63:0] v, input logic [15:0] y);
	in_data <= v;
	repeat (3) begin
		@(posedge core_clk);
		while (out_valid !== 1'b1) @(posedge core_clk);
	end
	check({16'h0000, out_value}, {16'h0000, y});
endtask

////////////////////////////////////////
initial begin
	#150000;
	num_errors++;
	give_verdict;
end

initial begin
	repeat (16) @(posedge core_clk);
	rst <= 1'b0;
	@(posedge core_clk);
	rchk(8'h00, 32'h0);
	rchk(8'hC0, 32'h2);
	rchk(8'hC4, 32'h0);
	bus(1'b1, 8'hC0, 32'h1);
	rchk(8'hC0, 32'h2);
	rchk(8'h14, 32'h0);
	for (i = 10; i > 0; i--)
		bus(1'b1, 8'h40 + 8'(4 * i), i > 1 ? 32'h00C8 : 32'h0064);
	bus(1'b1, 8'h44, 32'h012C);
	rchk(8'h44, 32'h00C8);
	bus(1'b1, 8'h44, 32'h0064);
	// y0 20, y1 -50, y2 300, the rest 1000 so the cut shows in min/max
	for (i = 0; i < 11; i++)
		bus(1'b1, 8'h80 + 8'(4 * i), i == 0 ? 32'h00000014 :
			i == 1 ? 32'hFFFFFFCE : i == 2 ? 32'h0000012C : 32'h000003E8);
	bus(1'b1, 8'hC4, 32'h1);
	bus(1'b1, 8'hC8, 32'h2);
	rchk(8'h84, 32'hFFFFFFCE);
	for (i = 0; i < 6; i++)
		ochk({48'h0, xs[i]}, ys[i]);
	check({16'h0000, out_min}, 32'h0000FFCE);
	check({16'h0000, out_max}, 32'h0000012C);
	rchk(8'h08, 32'hFFFFFFCE);
	bus(1'b1, 8'hC8, 32'h0);
	ochk({48'h0, 16'h01F4}, 16'hFFCE);
	check({16'h0000, out_max}, 32'h00000014);
	bus(1'b1, 8'h00, 32'h20);
	ochk({16'h0, 16'h0032, 32'h0}, 16'hFFF1);
	in_data <= 64'h0;
	bus(1'b1, 8'h00, 32'h21);
	rchk(8'h00, 32'h21);
	repeat (40) @(posedge core_clk);
	rchk(8'h10, 32'h0);
	in_data <= 64'h0000000100000000;
	repeat (100) @(posedge core_clk);
	in_data <= 64'h0;
	repeat (8) @(posedge core_clk);
	bus(1'b0, 8'h10, 32'h0);
	t = rd;
	check({31'h0, t >= 32'h14 && t <= 32'h1A}, 32'h1);
	repeat (40) @(posedge core_clk);
	rchk(8'h10, t);
	in_data <= 64'h0000000100000000;
	repeat (12) @(posedge core_clk);
	bus(1'b0, 8'h10, 32'h0);
	check({31'h0, rd < 32'h5}, 32'h1);
	repeat (500) @(posedge core_clk);
	rchk(8'h10, 32'h64);
	check({16'h0000, out_value}, 32'h0000FFCE);
	bus(1'b1, 8'h00, 32'h23);
	repeat (8) @(posedge core_clk);
	bus(1'b0, 8'h10, 32'h0);
	check({31'h0, rd < 32'h64}, 32'h1);
	ce <= 1'b0;
	repeat (20) @(posedge core_clk);
	check({31'h0, hreadyout}, 32'h0);
	ce <= 1'b1;
	@(posedge core_clk);
	give_verdict;
end
endmodule
`default_nettype wire
